// ### rtl/dtle_pkg.sv
// Purpose: Shared constants and types of the DS3 transmit line encoder
// Assumes: 125 MHz system clock, AXI4-Lite with 32-bit data
// Notes: Register byte address is four times the register index
package dtle_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int LOSS_TIME_NS = 512;
	// Longest time without a line clock edge, rounded down
	localparam int LOSS_CYCLES_DEF = (LOSS_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : LOSS_TIME_NS / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH_DEF = 4;
	localparam int FIFO_WIDTH = 2;
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;

	localparam int CTRL_IDX = 1;
	localparam int STAT_IDX = 2;
	// Byte address is the register index times four
	localparam logic [AXI_ADDR_W-1:0] CTRL_ADDR = AXI_ADDR_W'(CTRL_IDX * 4);
	localparam logic [AXI_ADDR_W-1:0] STAT_ADDR = AXI_ADDR_W'(STAT_IDX * 4);

	localparam logic [7:0] CTRL_RESET = 8'ha0;
	localparam logic [7:0] CTRL_WMASK = 8'hbf;
	localparam int CTRL_TX_LOSS_DIS = 7;
	localparam int CTRL_LOSS = 6;
	localparam int CTRL_RX_LOSS_DIS = 5;
	localparam int CTRL_ZERO_SUBST_DIS = 4;
	localparam int CTRL_SINGLE_RAIL = 3;
	localparam int CTRL_TX_EDGE_INV = 2;
	localparam int CTRL_RX_EDGE_INV = 1;
	localparam int CTRL_REFRAME = 0;

	localparam int STAT_UNDERRUN = 0;
	localparam int STAT_FIFO_EMPTY = 1;

	localparam int FIFO_BIT = 0;
	localparam int FIFO_FRAME = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		SYM_ZERO = 4'h1,
		SYM_ONE = 4'h2,
		SYM_BIP = 4'h4,
		SYM_VIOL = 4'h8
	} dtle_sym_t;
endpackage

// ### rtl/dtle_stream_if.sv
// Purpose: Valid/ready stream between encoder and its FIFO
// Assumes: Transfer when valid and ready are both high
// Notes: None
`timescale 1ns/100ps
interface dtle_stream_if #(parameter int W = 2);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// ### rtl/dtle_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: WIDTH matches the width of both stream interfaces
// Notes: Ready on the write side drops only when full
`timescale 1ns/100ps
module dtle_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	dtle_stream_if.snk wr,
	dtle_stream_if.src rd
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wp;
	logic [PW-1:0] rp;
	logic [CW-1:0] cnt;
	logic push;
	logic pop;

	assign wr.ready = (cnt != CW'(DEPTH));
	assign rd.valid = (cnt != '0);
	assign rd.data = mem[rp];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wp] <= wr.data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			if (push) begin
				wp <= bump(wp);
			end
			if (pop) begin
				rp <= bump(rp);
			end
			if (push && !pop) begin
				cnt <= cnt + 1'b1;
			end else if (pop && !push) begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule

// ### rtl/dtle_line_encoder.sv
// Purpose: DS3 transmit line interface: single rail, AMI or B3ZS onto two rails
// Assumes: Line clock arrives from outside and is resampled by aclk
// Notes: Three-bit lookahead window delays every mode by three line bits
// Contract
// RULE1 - Single rail: frame bits go out as NRZ on the positive rail.
// RULE2 - Single rail: negative rail high one bit at each frame start, else low.
// RULE3 - Dual rail: positive rail high when a positive pulse is wanted.
// RULE4 - Dual rail: negative rail high for a negative pulse; zero drives neither.
// RULE5 - The line unit samples both rails with the supplied line clock.
// RULE6 - Control bit 3 selects dual rail at 0, single rail at 1.
// RULE7 - After reset the block runs dual rail; bit 3 resets to zero.
// RULE8 - AMI: each mark opposite in polarity to the previous mark.
// RULE9 - B3ZS: every three zeros become 00V or B0V.
// RULE10 - Substitution keeps an odd count of B pulses between violations.
// RULE11 - Control bit 4 selects B3ZS at 0, plain AMI at 1.
// RULE12 - Line code bit is ignored in single rail mode.
// RULE13 - Control bit 2 selects which line clock edge updates the rails.
// RULE14 - Bit 2 at 0 updates on rising edge, at 1 on falling edge.
// RULE15 - Exactly one encoded bit per line clock period in every mode.
// RULE16 - Polarity tracking starts from a fixed value after reset.
`timescale 1ns/100ps
module dtle_line_encoder
	import dtle_pkg::*;
#(
	parameter int LOSS_CYCLES = LOSS_CYCLES_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_bit,
	input wire logic tx_frame_start,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic line_clk_in,
	output logic line_clock_out,
	output logic positive_rail_out,
	output logic negative_rail_out
);
	localparam int LCW = $clog2(LOSS_CYCLES + 1);

	logic [7:0] line_io_control;
	logic underrun;
	logic loss;
	logic [LCW-1:0] idle_cnt;

	logic aw_got;
	logic w_got;
	logic [AXI_ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic do_write;

	logic clk_s1;
	logic clk_s2;
	logic clk_s3;
	logic rise;
	logic fall;
	logic emit;

	dtle_sym_t win [3];
	logic [2:0] raw;
	logic [2:0] frm;
	logic last_pos;
	logic parity;
	logic next_last_pos;
	logic next_parity;
	logic new_bit;
	logic new_frm;
	logic single_mode;
	logic b3zs_mode;
	logic subst;

	dtle_stream_if #(.W(FIFO_WIDTH)) in_if ();
	dtle_stream_if #(.W(FIFO_WIDTH)) out_if ();

	function automatic logic hit_ctrl(input logic [AXI_ADDR_W-1:0] a);
		hit_ctrl = ({a[AXI_ADDR_W-1:2], 2'h0} == CTRL_ADDR);
	endfunction

	function automatic logic hit_stat(input logic [AXI_ADDR_W-1:0] a);
		hit_stat = ({a[AXI_ADDR_W-1:2], 2'h0} == STAT_ADDR);
	endfunction

	// Framer stream into the FIFO; tx_ready is true back-pressure
	assign in_if.data = {tx_frame_start, tx_bit};
	assign in_if.valid = tx_valid;
	assign tx_ready = in_if.ready;

	dtle_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr(in_if),
		.rd(out_if)
	);

	// Drained once per line bit, so a fast source stalls
	assign out_if.ready = emit;
	assign new_bit = out_if.valid ? out_if.data[FIFO_BIT] : 1'b0;
	assign new_frm = out_if.valid ? out_if.data[FIFO_FRAME] : 1'b0;

	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready = !w_got && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_got && w_got && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_byte <= '0;
			w_lane0 <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_got <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_got <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (hit_ctrl(aw_addr) || hit_stat(aw_addr)) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Bit 6 is the live loss flag and cannot be written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_io_control <= CTRL_RESET; // RULE7
		end else if (do_write && w_lane0 && hit_ctrl(aw_addr)) begin
			line_io_control <= w_byte & CTRL_WMASK; // RULE6 RULE11 RULE13
		end
	end

	// New underrun beats a write-one-to-clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			underrun <= 1'b0;
		end else if (emit && !out_if.valid) begin
			underrun <= 1'b1;
		end else if (do_write && w_lane0 && hit_stat(aw_addr) && w_byte[STAT_UNDERRUN]) begin
			underrun <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			if (hit_ctrl(s_axi_araddr)) begin
				s_axi_rdata <= {24'h000000, line_io_control[7], loss, line_io_control[5:0]};
			end else if (hit_stat(s_axi_araddr)) begin
				s_axi_rdata <= {30'h00000000, !out_if.valid, underrun};
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Line clock resampled; clk_s2 and clk_s3 feed the edge logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
		end else begin
			clk_s1 <= line_clk_in;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
		end
	end

	assign rise = clk_s2 && !clk_s3;
	assign fall = !clk_s2 && clk_s3;
	// Rails and clock copy leave on the same aclk edge
	assign line_clock_out = clk_s3; // RULE5
	assign emit = line_io_control[CTRL_TX_EDGE_INV] ? fall : rise; // RULE14 RULE15

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_cnt <= '0;
			loss <= 1'b0;
		end else if (rise || fall) begin
			idle_cnt <= '0;
			loss <= 1'b0;
		end else if (idle_cnt != LCW'(LOSS_CYCLES)) begin
			idle_cnt <= idle_cnt + 1'b1;
		end else begin
			loss <= !line_io_control[CTRL_TX_LOSS_DIS];
		end
	end

	assign single_mode = line_io_control[CTRL_SINGLE_RAIL]; // RULE6
	assign b3zs_mode = !single_mode && !line_io_control[CTRL_ZERO_SUBST_DIS]; // RULE11 RULE12

	// Pulse polarity equals the updated last polarity for B, one and V alike
	always_comb begin
		next_last_pos = last_pos;
		next_parity = parity;
		case (win[2])
			SYM_ONE, SYM_BIP: begin
				next_last_pos = !last_pos; // RULE8
				next_parity = !parity;
			end
			SYM_VIOL: begin
				next_parity = 1'b0;
			end
			default: begin
				next_parity = parity;
			end
		endcase
	end

	// Odd count so far: 00V; even: B0V, which makes it odd
	assign subst = b3zs_mode && !new_bit && (win[1] == SYM_ZERO) && (win[0] == SYM_ZERO); // RULE9

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_pos <= 1'b0; // RULE16
			parity <= 1'b0; // RULE16
		end else if (emit && !single_mode) begin
			last_pos <= next_last_pos;
			parity <= next_parity;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win[0] <= SYM_ZERO;
			win[1] <= SYM_ZERO;
			win[2] <= SYM_ZERO;
			raw <= '0;
			frm <= '0;
		end else if (emit) begin
			raw <= {raw[1:0], new_bit};
			frm <= {frm[1:0], new_frm};
			if (subst) begin
				win[2] <= next_parity ? SYM_ZERO : SYM_BIP; // RULE10
				win[1] <= SYM_ZERO;
				win[0] <= SYM_VIOL; // RULE9
			end else begin
				win[2] <= win[1];
				win[1] <= win[0];
				win[0] <= new_bit ? SYM_ONE : SYM_ZERO;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			positive_rail_out <= 1'b0;
			negative_rail_out <= 1'b0;
		end else if (emit) begin
			if (single_mode) begin
				positive_rail_out <= raw[2]; // RULE1
				negative_rail_out <= frm[2]; // RULE2
			end else begin
				positive_rail_out <= (win[2] != SYM_ZERO) && next_last_pos; // RULE3
				negative_rail_out <= (win[2] != SYM_ZERO) && !next_last_pos; // RULE4
			end
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_single_nrz_data: assert property (emit && single_mode |=> positive_rail_out == $past(raw[2])) // RULE1
		else $error("single rail data mismatch");
	a_single_frame_mark: assert property (emit && single_mode |=> negative_rail_out == $past(frm[2])) // RULE2
		else $error("frame marker mismatch");
	a_dual_zero_quiet: assert property (emit && !single_mode && win[2] == SYM_ZERO
		|=> !positive_rail_out && !negative_rail_out) // RULE4
		else $error("zero sent as a pulse");
	a_ami_mark_alternates: assert property (emit && !single_mode && win[2] == SYM_ONE
		|=> positive_rail_out == !$past(last_pos) && negative_rail_out == $past(last_pos)) // RULE8
		else $error("mark polarity did not alternate");
	a_dual_one_rail: assert property (emit && !single_mode && win[2] != SYM_ZERO
		|=> positive_rail_out != negative_rail_out) // RULE3
		else $error("pulse not on exactly one rail");
	a_b3zs_no_run: assert property (emit && b3zs_mode && $past(b3zs_mode) && $past(b3zs_mode, 2)
		|=> !(win[0] == SYM_ZERO && win[1] == SYM_ZERO && win[2] == SYM_ZERO)) // RULE9
		else $error("three zeros left unsubstituted");
	a_viol_odd_count: assert property (emit && !single_mode && win[2] == SYM_VIOL |-> parity) // RULE10
		else $error("even B count before violation");
	a_viol_same_pol: assert property (emit && !single_mode && win[2] == SYM_VIOL
		|=> positive_rail_out == $past(last_pos)) // RULE9
		else $error("violation polarity wrong");
	a_rails_on_edge: assert property (!emit |=> $stable(positive_rail_out) && $stable(negative_rail_out)) // RULE13
		else $error("rails changed off the line edge");
	a_edge_selected: assert property ($changed(positive_rail_out) || $changed(negative_rail_out)
		|-> ($past(line_io_control[CTRL_TX_EDGE_INV]) ? $fell(line_clock_out) : $rose(line_clock_out))) // RULE14
		else $error("rails moved on the wrong line clock edge");
	a_one_bit_period: assert property (emit |=> !emit ##1 !emit) // RULE15
		else $error("two line bits in one period");
	a_reset_dual_mode: assert property ($rose(aresetn) |-> !single_mode && !last_pos && !parity) // RULE7
		else $error("reset state not dual rail");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");

	c_b3zs_violation: cover property (emit && b3zs_mode && win[2] == SYM_VIOL);
	c_single_frame: cover property (emit && single_mode && frm[2]);
	c_fifo_full: cover property (!tx_ready && tx_valid);
	c_underrun: cover property (emit && !out_if.valid);
endmodule

// ### sim/dtle_liu_model.sv
// Purpose: Behavioural line unit that samples both rails once per line period
// Assumes: edge_inv mirrors control bit 2 of the block under test
// Notes: Samples on the edge opposite the update edge, for set-up margin
`timescale 1ns/100ps
module dtle_liu_model (
	input wire logic aclk,
	input wire logic line_clk,
	input wire logic edge_inv,
	input wire logic pos,
	input wire logic neg,
	output logic sym_valid,
	output logic sym_pos,
	output logic sym_neg
);
	logic clk_q = 1'b0;

	always @(posedge aclk) begin
		clk_q <= line_clk;
		sym_valid <= (clk_q != line_clk) && (line_clk == edge_inv);
		sym_pos <= pos;
		sym_neg <= neg;
	end
endmodule

// ### sim/dtle_line_encoder_tb_top.sv
// Purpose: Self-checking bench for the DS3 transmit line encoder
// Assumes: Bits are offered faster than the line drains them
// Notes: Rails are decoded back to bits, so no latency figure is assumed
`timescale 1ns/100ps
module dtle_line_encoder_tb_top;
	import dtle_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, line_clk = 1'b0, lc_run = 1'b1, en = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, cfg = 8'ha0;
	logic [31:0] wdata = 32'h0;
	logic tx_bit = 1'b0, tx_fs = 1'b0, tx_valid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tx_ready, lco, pos, neg, sv, sp, sn;
	logic [1:0] bresp, rresp, pr_rails;
	logic [31:0] rdata;
	logic [1:0] symq[$], bq[$];
	logic [33:0] rq[$];
	logic ln, hl, hv, h0, h1, al, seen;
	int bc, zr, hc, err_count = 0, samples_checked = 0;
	logic [7:0] cfgs[6] = '{8'ha0, 8'hb0, 8'ha4, 8'ha8, 8'hb8, 8'hb4};

	always #4 aclk = ~aclk;
	// Offset start keeps line clock edges 0.9 ns ahead of aclk rising edges
	initial begin
		#3.1;
		forever #32 if (lc_run) line_clk = ~line_clk;
	end

	dtle_line_encoder #(.LOSS_CYCLES(16), .FIFO_DEPTH(4)) uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_bit(tx_bit),
		.tx_frame_start(tx_fs), .tx_valid(tx_valid), .tx_ready(tx_ready), .line_clk_in(line_clk),
		.line_clock_out(lco), .positive_rail_out(pos), .negative_rail_out(neg));

	dtle_liu_model liu (.aclk(aclk), .line_clk(lco), .edge_inv(cfg[CTRL_TX_EDGE_INV]), .pos(pos),
		.neg(neg), .sym_valid(sv), .sym_pos(sp), .sym_neg(sn));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk_flag(string what, logic [1:0] e, logic [1:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_word(string what, logic [33:0] e, logic [33:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic axi_write(logic [7:0] a, logic [7:0] d, logic [1:0] r);
		int n;
		logic pa, pw, pb, ta, tw, tb;
		bq.push_back(r);
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && (pa || pw || pb); n++) begin
			@(negedge aclk);
			ta = pa && awready === 1'b1;
			tw = pw && wready === 1'b1;
			tb = !pa && !pw && bvalid === 1'b1;
			@(posedge aclk);
			if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
			if (tw) begin wvalid <= 1'b0; pw = 1'b0; end
			if (tb) begin bready <= 1'b0; pb = 1'b0; end
		end
		if (pb) begin err_count++; end_sim(); end
	endtask

	task automatic axi_read(logic [7:0] a, logic [33:0] e);
		int n;
		logic pa, pr, ta, tr;
		rq.push_back(e);
		pa = 1'b1;
		pr = 1'b1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && pr; n++) begin
			@(negedge aclk);
			ta = pa && arready === 1'b1;
			tr = !pa && rvalid === 1'b1;
			@(posedge aclk);
			if (ta) begin arvalid <= 1'b0; pa = 1'b0; end
			if (tr) begin rready <= 1'b0; pr = 1'b0; end
		end
		if (pr) begin err_count++; end_sim(); end
	endtask

	// Zero runs of 3 and 10 up front, then random bits; frames of 16 bits
	task automatic send(int nb);
		int i, n;
		logic b, f, t;
		@(posedge aclk);
		for (i = 0; i < nb; i++) begin
			b = (i < 16) ? 1'(16'h8801 >> (15 - i)) : 1'($urandom);
			f = (i % 16 == 0);
			tx_bit <= b;
			tx_fs <= f;
			tx_valid <= 1'b1;
			t = 1'b0;
			for (n = 0; n < 200 && !t; n++) begin
				@(negedge aclk);
				t = tx_ready === 1'b1;
				@(posedge aclk);
			end
			if (!t) begin err_count++; end_sim(); end
			symq.push_back({f, b});
		end
		tx_valid <= 1'b0;
	endtask

	task automatic run_test(logic [7:0] c);
		int n;
		aresetn <= 1'b0;
		cfg <= c;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_write(CTRL_ADDR, c, RESP_OKAY);
		// Let the window filled under the old mode drain first
		repeat (96) @(posedge aclk);
		en <= 1'b1;
		send(48);
		for (n = 0; n < 3000 && symq.size() > 0; n++) @(posedge aclk);
		if (symq.size() > 0) begin err_count++; end_sim(); end
		en <= 1'b0;
		$display("test control %h done, mismatches %0d", c, err_count);
	endtask

	always @(posedge aclk) begin
		if (bvalid === 1'b1 && bready && bq.size() > 0) chk_flag("bresp", bq.pop_front(), bresp);
		if (rvalid === 1'b1 && rready && rq.size() > 0) chk_word("read", rq.pop_front(), {rresp, rdata});
		if (en && {pos, neg} !== pr_rails) chk_flag("edge", {1'b0, ~cfg[CTRL_TX_EDGE_INV]}, {1'b0, lco});
		pr_rails = {pos, neg};
	end

	always @(posedge aclk) begin : watch
		logic v, o;
		logic [1:0] e;
		if (!aresetn) begin
			{hl, hv, h0, h1, al, seen} = 6'h0;
			{bc, zr, hc} = {32'h0, 32'h0, 32'h0};
		end else if (sv === 1'b1) begin
			if (!seen && (sp || sn)) begin
				seen = 1'b1;
				chk_flag("first mark", 2'b01, {1'b0, sp});
			end
			if (cfg[CTRL_SINGLE_RAIL]) begin
				if (en && sn) al = 1'b1;
				// Expected bits wait in the queue until the first frame mark shows
				if (al) begin
					e = symq.size() > 0 ? symq.pop_front() : 2'b00;
					chk_flag("single rail", e, {sn, sp});
				end
			end else begin
				v = (sp || sn) && hl && (sn == ln);
				if (en) chk_flag("both rails", 2'b00, {1'b0, sp && sn});
				if (sp || sn) begin
					if (v) begin
						if (en) chk_flag("violation", 2'b00, {1'b0, cfg[CTRL_ZERO_SUBST_DIS]});
						if (en && hv) chk_flag("b count", 2'b01, {1'b0, bc[0]});
						{hv, h0, h1} = 3'b100;
						bc = 0;
					end else begin
						bc++;
					end
					ln = sn;
					hl = 1'b1;
					zr = 0;
				end else begin
					zr++;
					if (en && !cfg[CTRL_ZERO_SUBST_DIS]) chk_flag("zero run", 2'b00, {1'b0, zr > 2});
				end
				o = h0;
				h0 = h1;
				h1 = (sp || sn) && !v;
				hc++;
				if (en && hc > 2 && o) al = 1'b1;
				if (en && al) begin
					e = symq.size() > 0 ? symq.pop_front() : 2'b00;
					chk_flag("dual rail bit", {1'b0, e[0]}, {1'b0, o});
				end
			end
		end
	end

	initial begin
		void'($urandom(11796));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(CTRL_ADDR, {RESP_OKAY, 24'h0, CTRL_RESET});
		axi_write(CTRL_ADDR, 8'hff, RESP_OKAY);
		axi_read(CTRL_ADDR, {RESP_OKAY, 24'h0, 8'hbf});
		axi_write(8'h40, 8'h55, RESP_SLVERR);
		axi_read(8'h40, {RESP_SLVERR, 32'h0});
		axi_read(STAT_ADDR, {RESP_OKAY, 24'h0, 8'h03});
		axi_write(CTRL_ADDR, 8'h20, RESP_OKAY);
		lc_run = 1'b0;
		repeat (40) @(posedge aclk);
		axi_read(CTRL_ADDR, {RESP_OKAY, 24'h0, 8'h60});
		// No line edges now, so the cleared underrun stays clear
		axi_write(STAT_ADDR, 8'h01, RESP_OKAY);
		axi_read(STAT_ADDR, {RESP_OKAY, 24'h0, 8'h02});
		lc_run = 1'b1;
		$display("test registers done, mismatches %0d", err_count);
		foreach (cfgs[k]) run_test(cfgs[k]);
		end_sim();
	end
endmodule
